// ==== logic/smr_regs.sv ====
// register bank, keyed chip reset, scan control and conversion pacing of the sensor monitor
`timescale 1ns/100ps
`default_nettype none
`include "smr_defines.svh"
module smr_regs (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_gcall_reset,
   input wire logic i_hs_mode,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic i_scl_tick,
   input wire logic i_osc_a_tick,
   input wire logic i_osc_b_tick,
   input wire logic i_smp_valid,
   input wire logic i_smp_ch,
   input wire logic [11:0] i_smp_data,
   input wire logic i_smp_out_of_window,
   input wire logic i_smp_below,
   output logic [7:0] o_reg_rdata,
   output logic o_reg_rvalid,
   output smr_pkg::smr_cfg_t o_cfg,
   output logic o_scan_running,
   output logic o_conv_start,
   output logic o_cal_start,
   output logic o_chip_reset,
   output logic o_alert
);
   smr_pkg::smr_state_t q;
   smr_pkg::smr_state_t next_q;
   smr_pkg::smr_state_t dflt;
   logic soft_rst;
   logic wr_key_ok;
   logic [1:0] dev_mode;
   logic auto_like;
   logic osc_tick;
   logic [1:0] set_low;
   logic [1:0] set_high;
   logic [7:0] evt_new;
   logic hit;

   always_comb
   begin
      dflt = '0;
      dflt.scan = smr_pkg::SMR_IDLE;
      soft_rst = i_gcall_reset || q.chip_rst;
      wr_key_ok = (q.key == `SMR_UNLOCK_WORD);
      unique case (q.cfg.opmode)
         `SMR_OPMODE_AUTO: dev_mode = `SMR_STAT_AUTO;
         `SMR_OPMODE_PREC: dev_mode = `SMR_STAT_PREC;
         default: dev_mode = `SMR_STAT_MANUAL;
      endcase
      auto_like = (dev_mode != `SMR_STAT_MANUAL);
      osc_tick = q.cfg.oscillator_choice ? i_osc_b_tick : i_osc_a_tick;
      set_low = 2'h0;
      set_high = 2'h0;
      evt_new = 8'h00;
      hit = 1'b0;
      next_q = q;
      next_q.conv = 1'b0;
      next_q.cal = 1'b0;
      next_q.chip_rst = 1'b0;
      next_q.rd_valid = 1'b0;

      // read path, one cycle after the strobe; unmapped reads give zero
      if (i_reg_rd)
      begin
         next_q.rd_valid = 1'b1;
         unique case (i_reg_addr)
            `SMR_A_MODE_STAT: next_q.rd_data = {5'h00, i_hs_mode, dev_mode};
            `SMR_A_BUF_STAT: next_q.rd_data = {3'h0, q.buf_cnt};
            `SMR_A_ACC_STAT: next_q.rd_data = {6'h00, q.n1 == `SMR_ACC_SAMPLES,
                                               q.n0 == `SMR_ACC_SAMPLES};
            `SMR_A_FIRST_CH: next_q.rd_data = {7'h00, q.first_ch};
            `SMR_A_SCAN_STAT: next_q.rd_data = {7'h00, q.scan == smr_pkg::SMR_RUN};
            `SMR_A_SUM0_LO: next_q.rd_data = q.sum0[7:0];
            `SMR_A_SUM0_HI: next_q.rd_data = q.sum0[15:8];
            `SMR_A_SUM1_LO: next_q.rd_data = q.sum1[7:0];
            `SMR_A_SUM1_HI: next_q.rd_data = q.sum1[15:8];
            `SMR_A_LOW_FLAGS: next_q.rd_data = {6'h00, q.low_flags};
            `SMR_A_HIGH_FLAGS: next_q.rd_data = {6'h00, q.high_flags};
            `SMR_A_KEY: next_q.rd_data = {4'h0, q.key};
            `SMR_A_OSC: next_q.rd_data = {7'h00, q.cfg.oscillator_choice};
            `SMR_A_CYCLES: next_q.rd_data = q.cfg.cycle_count;
            `SMR_A_OPMODE: next_q.rd_data = {5'h00, q.cfg.opmode};
            `SMR_A_SCAN_CH: next_q.rd_data = {6'h00, q.cfg.scan_ch_en};
            `SMR_A_INPUT_CFG: next_q.rd_data = {6'h00, q.cfg.input_cfg};
            `SMR_A_OUT_FMT: next_q.rd_data = q.cfg.out_fmt;
            `SMR_A_BUF_MODE: next_q.rd_data = q.cfg.buf_mode;
            `SMR_A_ACCUMULATOR_ENABLE: next_q.rd_data = {7'h00, q.cfg.accumulator_enable};
            `SMR_A_ALERT_CH: next_q.rd_data = {6'h00, q.cfg.alert_ch_en};
            `SMR_A_EVT_LIMIT: next_q.rd_data = q.cfg.evt_limit;
            `SMR_A_ALERT_BLK: next_q.rd_data = {7'h00, q.cfg.alert_blk_en};
            `SMR_A_UP0_LO: next_q.rd_data = q.cfg.upper0[7:0];
            `SMR_A_UP0_HI: next_q.rd_data = q.cfg.upper0[15:8];
            `SMR_A_LO0_LO: next_q.rd_data = q.cfg.lower0[7:0];
            `SMR_A_LO0_HI: next_q.rd_data = q.cfg.lower0[15:8];
            `SMR_A_UP1_LO: next_q.rd_data = q.cfg.upper1[7:0];
            `SMR_A_UP1_HI: next_q.rd_data = q.cfg.upper1[15:8];
            `SMR_A_LO1_LO: next_q.rd_data = q.cfg.lower1[7:0];
            `SMR_A_LO1_HI: next_q.rd_data = q.cfg.lower1[15:8];
            `SMR_A_DB0: next_q.rd_data = q.cfg.deadband0;
            `SMR_A_DB1: next_q.rd_data = q.cfg.deadband1;
            default: next_q.rd_data = `SMR_RESET_BYTE;
         endcase
      end

      if (i_reg_wr)
      begin
         unique case (i_reg_addr)
            `SMR_A_KEY: next_q.key = i_reg_wdata[3:0];
            `SMR_A_CHIP_RST: next_q.chip_rst = wr_key_ok && i_reg_wdata[0];
            `SMR_A_CAL: next_q.cal = i_reg_wdata[0];
            `SMR_A_OSC: next_q.cfg.oscillator_choice = i_reg_wdata[0];
            `SMR_A_CYCLES: next_q.cfg.cycle_count = i_reg_wdata;
            `SMR_A_OPMODE: next_q.cfg.opmode = i_reg_wdata[2:0];
            `SMR_A_SCAN_CH: next_q.cfg.scan_ch_en = i_reg_wdata[1:0];
            `SMR_A_INPUT_CFG: next_q.cfg.input_cfg = i_reg_wdata[1:0];
            `SMR_A_OUT_FMT: next_q.cfg.out_fmt = i_reg_wdata;
            `SMR_A_BUF_MODE: next_q.cfg.buf_mode = i_reg_wdata;
            `SMR_A_ACCUMULATOR_ENABLE: next_q.cfg.accumulator_enable = i_reg_wdata[0];
            `SMR_A_ALERT_CH: next_q.cfg.alert_ch_en = i_reg_wdata[1:0];
            `SMR_A_EVT_LIMIT: next_q.cfg.evt_limit = i_reg_wdata;
            `SMR_A_ALERT_BLK: next_q.cfg.alert_blk_en = i_reg_wdata[0];
            `SMR_A_UP0_LO: next_q.cfg.upper0[7:0] = i_reg_wdata;
            `SMR_A_UP0_HI: next_q.cfg.upper0[15:8] = i_reg_wdata;
            `SMR_A_LO0_LO: next_q.cfg.lower0[7:0] = i_reg_wdata;
            `SMR_A_LO0_HI: next_q.cfg.lower0[15:8] = i_reg_wdata;
            `SMR_A_UP1_LO: next_q.cfg.upper1[7:0] = i_reg_wdata;
            `SMR_A_UP1_HI: next_q.cfg.upper1[15:8] = i_reg_wdata;
            `SMR_A_LO1_LO: next_q.cfg.lower1[7:0] = i_reg_wdata;
            `SMR_A_LO1_HI: next_q.cfg.lower1[15:8] = i_reg_wdata;
            `SMR_A_DB0: next_q.cfg.deadband0 = i_reg_wdata;
            `SMR_A_DB1: next_q.cfg.deadband1 = i_reg_wdata;
            `SMR_A_LOW_FLAGS: next_q.low_flags = q.low_flags & ~i_reg_wdata[1:0];
            `SMR_A_HIGH_FLAGS: next_q.high_flags = q.high_flags & ~i_reg_wdata[1:0];
            `SMR_A_SCAN_BEGIN:
            begin
               if (i_reg_wdata[0])
               begin
                  next_q.scan = smr_pkg::SMR_RUN;
                  next_q.rate_cnt = 8'h00;
                  next_q.sum0 = `SMR_RESET_SUM;
                  next_q.sum1 = `SMR_RESET_SUM;
                  next_q.n0 = 5'h00;
                  next_q.n1 = 5'h00;
                  next_q.buf_cnt = 5'h00;
               end
            end
            `SMR_A_SCAN_STOP:
            begin
               if (i_reg_wdata[0])
                  next_q.scan = smr_pkg::SMR_IDLE;
            end
            default: next_q.rd_valid = next_q.rd_valid;
         endcase
      end

      // pacing: serial clock in manual mode, divided oscillator otherwise
      if (!auto_like)
         next_q.conv = i_scl_tick;
      else if (q.scan == smr_pkg::SMR_RUN && osc_tick)
      begin
         if (q.rate_cnt >= q.cfg.cycle_count)
         begin
            next_q.conv = 1'b1;
            next_q.rate_cnt = 8'h00;
         end
         else
            next_q.rate_cnt = q.rate_cnt + 8'h01;
      end

      if (i_smp_valid && q.scan == smr_pkg::SMR_RUN)
      begin
         // high-precision sums, sixteen 12-bit samples fill 16 bits exactly
         if (dev_mode == `SMR_STAT_PREC && q.cfg.accumulator_enable)
         begin
            if (!i_smp_ch && q.n0 != `SMR_ACC_SAMPLES)
            begin
               next_q.sum0 = q.sum0 + {4'h0, i_smp_data};
               next_q.n0 = q.n0 + 5'h01;
            end
            if (i_smp_ch && q.n1 != `SMR_ACC_SAMPLES)
            begin
               next_q.sum1 = q.sum1 + {4'h0, i_smp_data};
               next_q.n1 = q.n1 + 5'h01;
            end
         end
         if (dev_mode == `SMR_STAT_AUTO && q.buf_cnt != `SMR_BUF_DEPTH)
            next_q.buf_cnt = q.buf_cnt + 5'h01;
         // consecutive out-of-window samples counted per channel, one shared limit
         if (q.cfg.alert_blk_en && q.cfg.alert_ch_en[i_smp_ch])
         begin
            if (i_smp_out_of_window)
            begin
               evt_new = i_smp_ch ? q.evt1 : q.evt0;
               hit = (evt_new >= q.cfg.evt_limit);
               if (evt_new != 8'hff)
                  evt_new = evt_new + 8'h01;
            end
            if (i_smp_ch)
               next_q.evt1 = evt_new;
            else
               next_q.evt0 = evt_new;
            if (hit && i_smp_below)
               set_low[i_smp_ch] = 1'b1;
            if (hit && !i_smp_below)
               set_high[i_smp_ch] = 1'b1;
         end
      end
      // set wins over a clear in the same cycle
      next_q.low_flags = next_q.low_flags | set_low;
      next_q.high_flags = next_q.high_flags | set_high;
      if ((q.low_flags | q.high_flags) == 2'h0 && (set_low | set_high) != 2'h0)
         next_q.first_ch = i_smp_ch;
      next_q.alert = (next_q.low_flags | next_q.high_flags) != 2'h0;

      // in high-precision mode a scan ends by itself once every scanned channel has its sixteen
      if (dev_mode == `SMR_STAT_PREC && q.scan == smr_pkg::SMR_RUN &&
          (!q.cfg.scan_ch_en[0] || q.n0 == `SMR_ACC_SAMPLES) &&
          (!q.cfg.scan_ch_en[1] || q.n1 == `SMR_ACC_SAMPLES))
         next_q.scan = smr_pkg::SMR_IDLE;

      // soft reset restores everything except the unlock key
      if (soft_rst)
      begin
         next_q = dflt;
         next_q.key = q.key;
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         q <= '0;
         q.scan <= smr_pkg::SMR_IDLE;
      end
      else
         q <= next_q;
   end

   assign o_reg_rdata = q.rd_data;
   assign o_reg_rvalid = q.rd_valid;
   assign o_cfg = q.cfg;
   assign o_scan_running = (q.scan == smr_pkg::SMR_RUN);
   assign o_conv_start = q.conv;
   assign o_cal_start = q.cal;
   assign o_chip_reset = q.chip_rst;
   assign o_alert = q.alert;

   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rst_n);

   chk_key_grants: assert property (i_reg_wr && i_reg_addr == `SMR_A_CHIP_RST && i_reg_wdata[0]
      && q.key == `SMR_UNLOCK_WORD && !soft_rst |=> o_chip_reset ##1 !o_chip_reset)
      else $error("keyed reset write did not pulse chip reset");
   chk_key_refuses: assert property (i_reg_wr && i_reg_addr == `SMR_A_CHIP_RST
      && q.key != `SMR_UNLOCK_WORD |=> !o_chip_reset)
      else $error("chip reset taken without unlock key");
   chk_key_survives: assert property (o_chip_reset |=> q.key == $past(q.key)
      && q.cfg.opmode == 3'h0)
      else $error("chip reset lost key or kept config");
   chk_scan_begin: assert property (i_reg_wr && i_reg_addr == `SMR_A_SCAN_BEGIN
      && i_reg_wdata[0] && !soft_rst |=> o_scan_running && q.n0 == 5'h00)
      else $error("scan did not begin");
   chk_scan_stop: assert property (i_reg_wr && i_reg_addr == `SMR_A_SCAN_STOP
      && i_reg_wdata[0] |=> !o_scan_running)
      else $error("scan did not stop");
   chk_flag_latch: assert property (q.low_flags[0] && !(i_reg_wr
      && i_reg_addr == `SMR_A_LOW_FLAGS && i_reg_wdata[0]) && !soft_rst |=> q.low_flags[0])
      else $error("low alert flag dropped without clear");
   chk_mode_report: assert property (i_reg_rd && i_reg_addr == `SMR_A_MODE_STAT
      && !soft_rst && q.cfg.opmode == `SMR_OPMODE_PREC
      |=> o_reg_rvalid && o_reg_rdata[1:0] == 2'h3)
      else $error("mode status wrong for high precision");
   chk_rate_divide: assert property (o_conv_start && $past(auto_like)
      |-> $past(q.rate_cnt) >= $past(q.cfg.cycle_count) && q.rate_cnt == 8'h00)
      else $error("conversion strobe before cycle count reached");
   chk_manual_pace: assert property (!auto_like && i_scl_tick && !soft_rst
      |=> o_conv_start)
      else $error("manual conversion did not follow serial clock");
   chk_cal_pulse: assert property (i_reg_wr && i_reg_addr == `SMR_A_CAL
      && i_reg_wdata[0] && !soft_rst |=> o_cal_start ##1 !o_cal_start)
      else $error("calibration start missing");
   chk_alert_gate: assert property (!q.cfg.alert_blk_en && !soft_rst
      |=> (q.low_flags | q.high_flags) == ($past(q.low_flags | q.high_flags)
      & (q.low_flags | q.high_flags)))
      else $error("alert flag set while block disabled");
   chk_key_write: assert property (i_reg_wr && i_reg_addr == `SMR_A_KEY && !soft_rst
      |=> q.key == $past(i_reg_wdata[3:0]))
      else $error("unlock key write not stored");
   chk_gcall_clear: assert property (i_gcall_reset |=> o_cfg == '0 && !o_scan_running
      && !o_alert && q.key == $past(q.key))
      else $error("general call left state or lost key");
   chk_sum_read: assert property (i_reg_rd && i_reg_addr == `SMR_A_SUM1_HI && !soft_rst
      |=> o_reg_rvalid && o_reg_rdata == $past(q.sum1[15:8]))
      else $error("channel 1 sum high byte misread");
   // first channel must not move while any flag still holds the alert
   chk_first_hold: assert property ((q.low_flags | q.high_flags) != 2'h0 && !soft_rst
      |=> q.first_ch == $past(q.first_ch))
      else $error("first alert channel changed while alert held");

   cov_keyed_reset: cover property (o_chip_reset);
   cov_alert: cover property (o_alert && o_scan_running);
   cov_prec_done: cover property (q.n0 == `SMR_ACC_SAMPLES);
   cov_auto_conv: cover property (o_conv_start && auto_like);
   cov_gcall: cover property (i_gcall_reset);
endmodule : smr_regs
`default_nettype wire

// ==== logic/smr_defines.svh ====
// register offsets, unlock word, mode codes, reset values and counts of the sensor-monitor register bank
`ifndef SMR_DEFINES_SVH
`define SMR_DEFINES_SVH
`define SMR_A_MODE_STAT 8'h00
`define SMR_A_BUF_STAT 8'h01
`define SMR_A_ACC_STAT 8'h02
`define SMR_A_FIRST_CH 8'h03
`define SMR_A_SCAN_STAT 8'h04
`define SMR_A_SUM0_LO 8'h08
`define SMR_A_SUM0_HI 8'h09
`define SMR_A_SUM1_LO 8'h0a
`define SMR_A_SUM1_HI 8'h0b
`define SMR_A_LOW_FLAGS 8'h0c
`define SMR_A_HIGH_FLAGS 8'h0e
`define SMR_A_CHIP_RST 8'h14
`define SMR_A_CAL 8'h15
`define SMR_A_KEY 8'h17
`define SMR_A_OSC 8'h18
`define SMR_A_CYCLES 8'h19
`define SMR_A_OPMODE 8'h1c
`define SMR_A_SCAN_BEGIN 8'h1e
`define SMR_A_SCAN_STOP 8'h1f
`define SMR_A_SCAN_CH 8'h20
`define SMR_A_INPUT_CFG 8'h24
`define SMR_A_OUT_FMT 8'h28
`define SMR_A_BUF_MODE 8'h2c
`define SMR_A_ACCUMULATOR_ENABLE 8'h30
`define SMR_A_ALERT_CH 8'h34
`define SMR_A_EVT_LIMIT 8'h36
`define SMR_A_ALERT_BLK 8'h37
`define SMR_A_UP0_LO 8'h38
`define SMR_A_UP0_HI 8'h39
`define SMR_A_LO0_LO 8'h3a
`define SMR_A_LO0_HI 8'h3b
`define SMR_A_UP1_LO 8'h3c
`define SMR_A_UP1_HI 8'h3d
`define SMR_A_LO1_LO 8'h3e
`define SMR_A_LO1_HI 8'h3f
`define SMR_A_DB0 8'h40
`define SMR_A_DB1 8'h41
`define SMR_UNLOCK_WORD 4'ha
`define SMR_OPMODE_AUTO 3'h6
`define SMR_OPMODE_PREC 3'h7
`define SMR_STAT_MANUAL 2'h0
`define SMR_STAT_AUTO 2'h2
`define SMR_STAT_PREC 2'h3
`define SMR_ACC_SAMPLES 5'h10
`define SMR_BUF_DEPTH 5'h10
`define SMR_RESET_BYTE 8'h00
`define SMR_RESET_SUM 16'h0000
`endif

// ==== logic/smr_pkg.sv ====
// types of the sensor-monitor register bank
package smr_pkg;
   typedef enum logic [0:0] {SMR_IDLE = 1'b0, SMR_RUN = 1'b1} smr_scan_t;
   typedef struct packed {
      logic [2:0] opmode;
      logic oscillator_choice;
      logic [7:0] cycle_count;
      logic [1:0] scan_ch_en;
      logic [1:0] input_cfg;
      logic [7:0] out_fmt;
      logic [7:0] buf_mode;
      logic accumulator_enable;
      logic [1:0] alert_ch_en;
      logic [7:0] evt_limit;
      logic alert_blk_en;
      logic [15:0] upper0;
      logic [15:0] lower0;
      logic [15:0] upper1;
      logic [15:0] lower1;
      logic [7:0] deadband0;
      logic [7:0] deadband1;
   } smr_cfg_t;
   typedef struct packed {
      smr_cfg_t cfg;
      logic [3:0] key;
      smr_scan_t scan;
      logic [7:0] rate_cnt;
      logic conv;
      logic [1:0] low_flags;
      logic [1:0] high_flags;
      logic first_ch;
      logic [15:0] sum0;
      logic [15:0] sum1;
      logic [4:0] n0;
      logic [4:0] n1;
      logic [4:0] buf_cnt;
      logic [7:0] evt0;
      logic [7:0] evt1;
      logic cal;
      logic chip_rst;
      logic [7:0] rd_data;
      logic rd_valid;
      logic alert;
   } smr_state_t;
endpackage : smr_pkg

// ==== tb/smr_host_model.sv ====
// host side model issuing decoded register byte accesses
`timescale 1ns/100ps
`default_nettype none
module smr_host_model (
   input wire logic i_core_clk,
   input wire logic i_reg_rvalid,
   input wire logic [7:0] i_reg_rdata,
   output logic [7:0] o_reg_addr,
   output logic [7:0] o_reg_wdata,
   output logic o_reg_wr,
   output logic o_reg_rd
);
   initial
   begin
      o_reg_addr = 8'h00;
      o_reg_wdata = 8'h00;
      o_reg_wr = 1'b0;
      o_reg_rd = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_core_clk);
      o_reg_addr = a;
      o_reg_wdata = d;
      o_reg_wr = 1'b1;
      @(negedge i_core_clk);
      o_reg_wr = 1'b0;
      // released byte must not linger as a valid value
      o_reg_wdata = ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge i_core_clk);
      o_reg_addr = a;
      o_reg_rd = 1'b1;
      @(negedge i_core_clk);
      // answer stands one cycle after the strobe edge; missing answer gives unknown
      d = i_reg_rvalid ? i_reg_rdata : 8'hxx;
      o_reg_rd = 1'b0;
   endtask : rd
endmodule : smr_host_model
`default_nettype wire

// ==== tb/tb_smr_regs.sv ====
// self-checking bench of the sensor-monitor register bank
`timescale 1ns/100ps
`default_nettype none
module tb_smr_regs;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic gcall = 1'b0;
   logic hs = 1'b0;
   logic scl = 1'b0;
   logic osc_a = 1'b0;
   logic osc_b = 1'b0;
   logic smp_valid = 1'b0;
   logic smp_ch = 1'b0;
   logic [11:0] smp_data = 12'h000;
   logic oow = 1'b0;
   logic below = 1'b0;
   logic [7:0] addr, wdata, rdata, v;
   logic wr, rd, rvalid, running, conv, cal, chip_rst, alert;
   smr_pkg::smr_cfg_t cfg;
   logic [15:0] sum;
   int errors = 0;
   int comparisons = 0;
   int seed = 21920;
   int cycles = 0;
   int n_conv = 0;
   int n_cal = 0;
   int n_rst = 0;
   int n0, k, t;
   localparam logic [7:0] rw_list [22] = '{8'h17, 8'h18, 8'h19, 8'h1c, 8'h20, 8'h24, 8'h28,
      8'h2c, 8'h30, 8'h34, 8'h36, 8'h37, 8'h38, 8'h39, 8'h3a, 8'h3b, 8'h3c, 8'h3d, 8'h3e,
      8'h3f, 8'h40, 8'h41};
   localparam logic [7:0] ro_list [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h09,
      8'h0a, 8'h0b, 8'h0c, 8'h0e};
   always #20 core_clk = ~core_clk;
   smr_host_model host_u (.i_core_clk(core_clk), .i_reg_rvalid(rvalid), .i_reg_rdata(rdata),
      .o_reg_addr(addr), .o_reg_wdata(wdata), .o_reg_wr(wr), .o_reg_rd(rd));
   smr_regs dut_u (.i_core_clk(core_clk), .i_rst_n(rst_n), .i_gcall_reset(gcall),
      .i_hs_mode(hs), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
      .i_scl_tick(scl), .i_osc_a_tick(osc_a), .i_osc_b_tick(osc_b), .i_smp_valid(smp_valid),
      .i_smp_ch(smp_ch), .i_smp_data(smp_data), .i_smp_out_of_window(oow),
      .i_smp_below(below), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .o_cfg(cfg),
      .o_scan_running(running), .o_conv_start(conv), .o_cal_start(cal),
      .o_chip_reset(chip_rst), .o_alert(alert));
   task automatic tally_and_finish;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : tally_and_finish
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      comparisons++;
      if (got !== exp)
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
      if (got !== exp)
         errors++;
   endtask : check
   task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string what);
      logic [7:0] d;
      host_u.rd(a, d);
      check(d, e, what);
   endtask : rchk
   task automatic idle(input int n);
      repeat (n) @(negedge core_clk);
   endtask : idle
   task automatic sample(input logic ch, input logic out, input logic lo);
      @(negedge core_clk);
      smp_valid = 1'b1;
      smp_ch = ch;
      smp_data = 12'($random(seed));
      oow = out;
      below = lo;
      @(negedge core_clk);
      smp_valid = 1'b0;
      smp_data = ~smp_data;
   endtask : sample
   // writable bits of each config byte
   function automatic logic [7:0] rw_mask(input logic [7:0] a);
      case (a)
         8'h17: return 8'h0f;
         8'h18, 8'h30, 8'h37: return 8'h01;
         8'h1c: return 8'h07;
         8'h20, 8'h24, 8'h34: return 8'h03;
         default: return 8'hff;
      endcase
   endfunction : rw_mask
   function automatic logic [1:0] mode_code(input logic [2:0] m);
      return (m == 3'h6) ? 2'h2 : (m == 3'h7) ? 2'h3 : 2'h0;
   endfunction : mode_code
   always @(posedge core_clk)
   begin
      cycles++;
      n_conv += int'(conv === 1'b1);
      n_cal += int'(cal === 1'b1);
      n_rst += int'(chip_rst === 1'b1);
      // whole sequence needs under five hundred cycles
      if (cycles == 20000)
      begin
         errors++;
         tally_and_finish();
      end
   end
   initial
   begin
      repeat (3) @(negedge core_clk);
      rst_n = 1'b1;
      foreach (rw_list[i]) rchk(rw_list[i], 8'h00, "config after reset");
      foreach (ro_list[i]) rchk(ro_list[i], 8'h00, "status after reset");
      foreach (rw_list[i])
      begin
         v = 8'($random(seed));
         host_u.wr(rw_list[i], v);
         rchk(rw_list[i], v & rw_mask(rw_list[i]), "readback");
      end
      host_u.wr(8'h00, 8'hff);
      host_u.wr(8'h05, 8'hff);
      rchk(8'h05, 8'h00, "unmapped read");
      for (int m = 0; m < 8; m++)
      begin
         host_u.wr(8'h1c, 8'(m));
         @(negedge core_clk);
         v = 8'($random(seed));
         hs = v[0];
         rchk(8'h00, {5'h00, hs, mode_code(3'(m))}, "mode status");
      end
      host_u.wr(8'h19, 8'h5a);
      host_u.wr(8'h17, 8'h05);
      host_u.wr(8'h14, 8'h01);
      rchk(8'h19, 8'h5a, "wrong key kept config");
      check(cfg.cycle_count, 8'h5a, "cycle count on config port");
      host_u.wr(8'h17, 8'hfa);
      host_u.wr(8'h14, 8'h00);
      rchk(8'h19, 8'h5a, "bit0 clear kept config");
      check(8'(n_rst), 8'h00, "no chip reset yet");
      host_u.wr(8'h14, 8'h01);
      idle(2);
      check(8'(n_rst), 8'h01, "chip reset pulse");
      rchk(8'h19, 8'h00, "config after chip reset");
      check(cfg.cycle_count, 8'h00, "config port after chip reset");
      rchk(8'h17, 8'h0a, "key survives chip reset");
      host_u.wr(8'h17, 8'h00);
      host_u.wr(8'h1c, 8'h07);
      @(negedge core_clk);
      gcall = 1'b1;
      @(negedge core_clk);
      gcall = 1'b0;
      rchk(8'h1c, 8'h00, "mode after general call");
      host_u.wr(8'h1e, 8'h01);
      check({7'h00, running}, 8'h01, "scan running");
      rchk(8'h04, 8'h01, "scan status");
      host_u.wr(8'h1f, 8'h01);
      check({7'h00, running}, 8'h00, "scan stopped");
      n0 = n_conv;
      t = 0;
      repeat (20)
      begin
         @(negedge core_clk);
         v = 8'($random(seed));
         scl = v[0];
         t += int'(v[0]);
      end
      @(negedge core_clk);
      scl = 1'b0;
      idle(2);
      check(8'(n_conv - n0), 8'(t), "manual conversions");
      for (int s = 0; s < 2; s++)
      begin
         k = $random(seed) & 3;
         host_u.wr(8'h1c, 8'h06);
         host_u.wr(8'h18, 8'(s));
         host_u.wr(8'h19, 8'(k));
         host_u.wr(8'h1e, 8'h01);
         n0 = n_conv;
         repeat (3 * (k + 1))
         begin
            @(negedge core_clk);
            osc_a = (s == 0);
            osc_b = (s == 1);
            @(negedge core_clk);
            osc_a = (s == 1);
            osc_b = (s == 0);
         end
         @(negedge core_clk);
         osc_a = 1'b0;
         osc_b = 1'b0;
         idle(2);
         check(8'(n_conv - n0), 8'h03, "paced conversions");
         host_u.wr(8'h1f, 8'h01);
      end
      host_u.wr(8'h37, 8'h00);
      host_u.wr(8'h34, 8'h03);
      host_u.wr(8'h36, 8'h02);
      host_u.wr(8'h1e, 8'h01);
      sample(1'b1, 1'b1, 1'b1);
      host_u.wr(8'h37, 8'h01);
      sample(1'b1, 1'b1, 1'b1);
      sample(1'b1, 1'b1, 1'b1);
      rchk(8'h0c, 8'h00, "below event limit");
      sample(1'b1, 1'b1, 1'b1);
      rchk(8'h0c, 8'h02, "low flag ch1");
      check({7'h00, alert}, 8'h01, "alert level");
      for (int i = 0; i < 5; i++) sample(1'b0, i != 2, 1'b0);
      rchk(8'h0e, 8'h00, "in-window restarts count");
      sample(1'b0, 1'b1, 1'b0);
      rchk(8'h0e, 8'h01, "high flag ch0");
      rchk(8'h03, 8'h01, "first alert channel");
      rchk(8'h01, 8'h0a, "samples counted");
      host_u.wr(8'h0c, 8'h02);
      rchk(8'h0c, 8'h00, "low flag cleared");
      check({7'h00, alert}, 8'h01, "alert held by high flag");
      host_u.wr(8'h0e, 8'h01);
      idle(1);
      check({7'h00, alert}, 8'h00, "alert cleared");
      host_u.wr(8'h1f, 8'h01);
      host_u.wr(8'h1c, 8'h07);
      host_u.wr(8'h30, 8'h01);
      host_u.wr(8'h20, 8'h01);
      host_u.wr(8'h1e, 8'h01);
      sum = 16'h0000;
      repeat (16)
      begin
         sample(1'b0, 1'b0, 1'b0);
         sum += {4'h0, ~smp_data};
      end
      idle(1);
      rchk(8'h08, sum[7:0], "sum ch0 low");
      rchk(8'h09, sum[15:8], "sum ch0 high");
      rchk(8'h0a, 8'h00, "sum ch1 low");
      rchk(8'h02, 8'h01, "sum complete");
      check({7'h00, running}, 8'h00, "scan ends after 16");
      n0 = n_cal;
      host_u.wr(8'h15, 8'h01);
      idle(2);
      check(8'(n_cal - n0), 8'h01, "calibration start");
      tally_and_finish();
   end
endmodule : tb_smr_regs
`default_nettype wire
